/* File: dcfpc_params.svh */
// Purpose: constants of the dual-clock FIFO port control
// Assumes: included by its bare name
// Notes:   offsets are byte addresses on a 32-bit APB
`ifndef DCFPC_PARAMS_SVH
`define DCFPC_PARAMS_SVH
`define DCFPC_ADDR_CTRL     12'h000
`define DCFPC_ADDR_STATUS   12'h004
`define DCFPC_ADDR_THRESH   12'h008
`define DCFPC_CTRL_RST      3'h0
`define DCFPC_CTRL_PGA      0
`define DCFPC_CTRL_PGB      1
`define DCFPC_CTRL_ODD      2
`define DCFPC_DEPTH         7'h40
`define DCFPC_OFFSET0       7'h10
`define DCFPC_OFFSET1       7'h0c
`define DCFPC_OFFSET2       7'h08
`define DCFPC_OFFSET3       7'h04
`define DCFPC_LAST_LONG     2'h0
`define DCFPC_LAST_WORD     2'h1
`define DCFPC_LAST_BYTE     2'h3
`endif

/* File: dcfpc_pkg.sv */
// Purpose: types of the dual-clock FIFO port control
// Assumes: nothing
// Notes:   structs carry pin groups and the status word
package dcfpc_pkg;
  typedef enum logic [1:0] {
    DCFPC_LONG = 2'b00,
    DCFPC_WORD = 2'b01,
    DCFPC_BYTE = 2'b10,
    DCFPC_MBOX = 2'b11
  } dcfpc_width_e;
  typedef enum logic [1:0] {
    DCFPC_NOSWAP   = 2'b00,
    DCFPC_BYTESWAP = 2'b01,
    DCFPC_WORDSWAP = 2'b10,
    DCFPC_BOTHSWAP = 2'b11
  } dcfpc_swap_e;
  typedef struct packed {
    logic        porta_clock;
    logic        porta_enable;
    logic        porta_direction_sel;
    logic        porta_mailbox_sel;
    logic [35:0] data;
  } dcfpc_porta_s;
  typedef struct packed {
    logic        portb_clock;
    logic        portb_enable;
    logic        portb_direction_sel;
    logic        portb_width_sel_hi;
    logic        portb_width_sel_lo;
    logic        endian_sel;
    logic        swap_mode_sel_hi;
    logic        swap_mode_sel_lo;
    logic [35:0] data;
  } dcfpc_portb_s;
  typedef struct packed {
    logic [1:0]   offset_sel;
    dcfpc_swap_e  swap;
    logic         endian;
    dcfpc_width_e width;
    logic         mail_to_a_full_n;
    logic         mail_to_b_full_n;
    logic         almost_empty_n;
    logic         empty_n;
    logic         almost_full_n;
    logic         full_n;
  } dcfpc_status_s;
endpackage : dcfpc_pkg

/* File: dcfpc_port_ctrl.sv */
// Purpose: port control of a 64 x 36 dual-clock FIFO with mailboxes
// Assumes: port clocks far slower than CLK; all port and offset-select pins pass two flops
// Notes:   FIFO array and flag counting sit outside this block
//
// Notes on behaviour
// - Port A mailbox reads get generated lane parity
// - Parity polarity follows odd/even select
// - Port B reads get generated lane parity
// - Reset: AF, mailbox flags high; others low
// - Reset release latches flag offset selects
// - Width and endian sampled, applied next edge
// - Port B widths: long, word, byte
// - Both width selects high access mailboxes
// - Swap mode latched at each long-word start
// - Four swap modes with any width
// - Port A direction high writes, low reads
// - Port A outputs off while direction high
// - Port B direction high writes, low reads
// - Port B outputs off while direction high
// - Port B reads and writes only with enable high; width and endian sample at every edge
// - Offset choice picks one of four presets
// - Mailbox to B: write fills, B read empties
// - Mailbox to A: write fills, A read empties
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`include "dcfpc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module dcfpc_port_ctrl (
  input  wire logic                CLK,
  input  wire logic                RST,
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [11:0]         PADDR,
  input  wire logic [31:0]         PWDATA,
  output var  logic [31:0]         PRDATA,
  output var  logic                PREADY,
  output var  logic                PSLVERR,
  input  wire dcfpc_pkg::dcfpc_porta_s PORTA_IN,
  input  wire dcfpc_pkg::dcfpc_portb_s PORTB_IN,
  input  wire logic                FLAG_OFFSET_SEL_LO,
  input  wire logic                FLAG_OFFSET_SEL_HI,
  input  wire logic [35:0]         FIFO_RD_DATA,
  input  wire logic                FIFO_EMPTY,
  input  wire logic                FIFO_FULL,
  input  wire logic [6:0]          FIFO_COUNT,
  output var  logic                FIFO_RD_REQ,
  output var  logic                FIFO_WR_REQ,
  output var  logic [35:0]         FIFO_WR_DATA,
  output var  logic [35:0]         PORTA_DATA_OUT,
  output var  logic                PORTA_DATA_OE_N,
  output var  logic [35:0]         PORTB_DATA_OUT,
  output var  logic                PORTB_DATA_OE_N,
  output var  logic                FULL_N,
  output var  logic                ALMOST_FULL_N,
  output var  logic                EMPTY_N,
  output var  logic                ALMOST_EMPTY_N,
  output var  logic                MAIL_TO_B_FULL_N,
  output var  logic                MAIL_TO_A_FULL_N
);
  import dcfpc_pkg::*;

  function automatic logic [35:0] swap_word(
    input logic [35:0] d,
    input dcfpc_swap_e m
  );
    logic [35:0] b;
    b = m[0] ? {d[26:18], d[35:27], d[8:0], d[17:9]} : d;
    swap_word = m[1] ? {b[17:0], b[35:18]} : b;
  endfunction : swap_word

  function automatic logic [35:0] add_parity(
    input logic [35:0] d,
    input logic        odd
  );
    add_parity = d;
    for (int i = 0; i < 4; i++) begin
      add_parity[9*i+8] = (^d[9*i +: 8]) ^ odd;
    end
  endfunction : add_parity

  dcfpc_porta_s  a_s1_reg;
  dcfpc_porta_s  a_s2_reg;
  dcfpc_portb_s  b_s1_reg;
  dcfpc_portb_s  b_s2_reg;
  logic [1:0]    fs_s1_reg;
  logic [1:0]    fs_s2_reg;
  logic          a_clk_d_reg;
  logic          b_clk_d_reg;
  logic          a_edge;
  logic          b_edge;
  logic [2:0]    ctrl_reg;
  logic          offset_taken_reg;
  logic [1:0]    offset_sel_reg;
  logic [6:0]    threshold_reg;
  dcfpc_width_e  width_pend_reg;
  dcfpc_width_e  width_reg;
  logic          endian_pend_reg;
  logic          endian_reg;
  dcfpc_swap_e   swap_reg;
  logic [1:0]    phase_reg;
  logic [1:0]    phase_last;
  logic [35:0]   hold_reg;
  logic [35:0]   mailbox_to_b;
  logic [35:0]   mailbox_to_a;
  logic          a_wr;
  logic          a_rd;
  logic          b_wr;
  logic          b_rd;
  logic          b_mbox;
  logic [35:0]   b_word;
  logic [35:0]   b_lanes;
  logic [1:0]    b_lane;
  dcfpc_status_s status;
  logic          apb_access;

  // Every pin, data included, rides the same two-flop delay so a
  // port clock edge and its qualifiers stay aligned
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      a_s1_reg  <= '0;
      a_s2_reg  <= '0;
      b_s1_reg  <= '0;
      b_s2_reg  <= '0;
    end else begin
      a_s1_reg  <= PORTA_IN;
      a_s2_reg  <= a_s1_reg;
      b_s1_reg  <= PORTB_IN;
      b_s2_reg  <= b_s1_reg;
    end
  end

  // Offset selects keep moving through reset, so the level present
  // as reset lifts is the one captured, not a cleared copy
  always_ff @(posedge CLK) begin
    fs_s1_reg <= {FLAG_OFFSET_SEL_HI, FLAG_OFFSET_SEL_LO};
    fs_s2_reg <= fs_s1_reg;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      a_clk_d_reg <= 1'b0;
      b_clk_d_reg <= 1'b0;
    end else begin
      a_clk_d_reg <= a_s2_reg.porta_clock;
      b_clk_d_reg <= b_s2_reg.portb_clock;
    end
  end

  assign a_edge = a_s2_reg.porta_clock & ~a_clk_d_reg;
  assign b_edge = b_s2_reg.portb_clock & ~b_clk_d_reg;

  // Port accesses decoded at port clock edges
  assign a_wr = a_edge & a_s2_reg.porta_enable
              & a_s2_reg.porta_direction_sel;
  assign a_rd = a_edge & a_s2_reg.porta_enable
              & ~a_s2_reg.porta_direction_sel;
  assign b_wr = b_edge & b_s2_reg.portb_enable
              & b_s2_reg.portb_direction_sel;
  assign b_rd = b_edge & b_s2_reg.portb_enable
              & ~b_s2_reg.portb_direction_sel;
  // Access at an edge uses the size latched at the edge before
  assign b_mbox = (width_pend_reg == DCFPC_MBOX);

  // Offset selects caught once, on the first cycle after release
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      offset_taken_reg <= 1'b0;
      offset_sel_reg   <= 2'h0;
      threshold_reg    <= `DCFPC_OFFSET0;
    end else if (!offset_taken_reg) begin
      offset_taken_reg <= 1'b1;
      offset_sel_reg   <= fs_s2_reg;
      case (fs_s2_reg)
        2'h0:    threshold_reg <= `DCFPC_OFFSET0;
        2'h1:    threshold_reg <= `DCFPC_OFFSET1;
        2'h2:    threshold_reg <= `DCFPC_OFFSET2;
        default: threshold_reg <= `DCFPC_OFFSET3;
      endcase
    end
  end

  // Bus size and endian: sampled at one edge, in force at the next
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      width_pend_reg  <= DCFPC_LONG;
      width_reg       <= DCFPC_LONG;
      endian_pend_reg <= 1'b0;
      endian_reg      <= 1'b0;
    end else if (b_edge) begin
      width_reg       <= width_pend_reg;
      endian_reg      <= endian_pend_reg;
      width_pend_reg  <= dcfpc_width_e'({
        b_s2_reg.portb_width_sel_hi,
        b_s2_reg.portb_width_sel_lo});
      endian_pend_reg <= b_s2_reg.endian_sel;
    end
  end

  always_comb begin
    case (width_pend_reg)
      DCFPC_WORD: phase_last = `DCFPC_LAST_WORD;
      DCFPC_BYTE: phase_last = `DCFPC_LAST_BYTE;
      default:    phase_last = `DCFPC_LAST_LONG;
    endcase
  end

  // Word under read: mailbox, a freshly popped FIFO word, or the rest
  // of a word already popped
  always_comb begin
    if (b_mbox) begin
      b_word = mailbox_to_b;
    end else if (phase_reg == 2'h0) begin
      b_word = swap_word(FIFO_RD_DATA, dcfpc_swap_e'({
        b_s2_reg.swap_mode_sel_hi,
        b_s2_reg.swap_mode_sel_lo}));
    end else begin
      b_word = hold_reg;
    end
  end

  // Narrow widths deliver lanes on the low bits, endian sets order
  always_comb begin
    b_lane = endian_pend_reg ? 2'h3 - phase_reg : phase_reg;
    case (width_pend_reg)
      DCFPC_WORD: begin
        b_lanes = (endian_pend_reg ^ phase_reg[0])
                ? {18'h0, b_word[35:18]}
                : {18'h0, b_word[17:0]};
      end
      DCFPC_BYTE: b_lanes = {27'h0, b_word[9*b_lane +: 9]};
      default:    b_lanes = b_word;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      phase_reg <= 2'h0;
      hold_reg  <= 36'h0;
      swap_reg  <= DCFPC_NOSWAP;
    end else if (b_rd && !b_mbox) begin
      if (phase_reg == 2'h0) begin
        hold_reg <= b_word;
        swap_reg <= dcfpc_swap_e'({
          b_s2_reg.swap_mode_sel_hi,
          b_s2_reg.swap_mode_sel_lo});
      end
      phase_reg <= (phase_reg >= phase_last) ? 2'h0
                 : phase_reg + 2'h1;
    end
  end

  // Output drivers off while the far side drives the bus
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PORTA_DATA_OE_N <= 1'b1;
      PORTB_DATA_OE_N <= 1'b1;
      PORTA_DATA_OUT  <= 36'h0;
      PORTB_DATA_OUT  <= 36'h0;
      FIFO_RD_REQ     <= 1'b0;
    end else begin
      PORTA_DATA_OE_N <= a_s2_reg.porta_direction_sel;
      PORTB_DATA_OE_N <= b_s2_reg.portb_direction_sel;
      FIFO_RD_REQ     <= b_rd & ~b_mbox & (phase_reg == 2'h0);
      if (a_rd) begin
        PORTA_DATA_OUT <= ctrl_reg[`DCFPC_CTRL_PGA]
          && a_s2_reg.porta_mailbox_sel
          ? add_parity(mailbox_to_a, ctrl_reg[`DCFPC_CTRL_ODD])
          : mailbox_to_a;
      end
      if (b_rd) begin
        PORTB_DATA_OUT <= ctrl_reg[`DCFPC_CTRL_PGB]
          ? add_parity(b_lanes, ctrl_reg[`DCFPC_CTRL_ODD])
          : b_lanes;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      FIFO_WR_REQ  <= 1'b0;
      FIFO_WR_DATA <= 36'h0;
    end else begin
      FIFO_WR_REQ <= a_wr & ~a_s2_reg.porta_mailbox_sel;
      if (a_wr) begin
        FIFO_WR_DATA <= a_s2_reg.data;
      end
    end
  end

  // Mailboxes: a write fills, the far port's read empties; a fill
  // beats an empty in the same cycle, but a write to a full mailbox is dropped
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mailbox_to_b     <= 36'h0;
      MAIL_TO_B_FULL_N <= 1'b1;
    end else if (a_wr && a_s2_reg.porta_mailbox_sel
                 && MAIL_TO_B_FULL_N) begin
      mailbox_to_b     <= a_s2_reg.data;
      MAIL_TO_B_FULL_N <= 1'b0;
    end else if (b_rd && b_mbox) begin
      MAIL_TO_B_FULL_N <= 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mailbox_to_a     <= 36'h0;
      MAIL_TO_A_FULL_N <= 1'b1;
    end else if (b_wr && b_mbox && MAIL_TO_A_FULL_N) begin
      mailbox_to_a     <= b_s2_reg.data;
      MAIL_TO_A_FULL_N <= 1'b0;
    end else if (a_rd && a_s2_reg.porta_mailbox_sel) begin
      MAIL_TO_A_FULL_N <= 1'b1;
    end
  end

  // Full and empty from the outside FIFO; almost flags from its counter against the chosen offset
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      FULL_N         <= 1'b0;
      ALMOST_FULL_N  <= 1'b1;
      EMPTY_N        <= 1'b0;
      ALMOST_EMPTY_N <= 1'b0;
    end else begin
      FULL_N         <= ~FIFO_FULL;
      ALMOST_FULL_N  <= FIFO_COUNT
                      < `DCFPC_DEPTH - threshold_reg;
      EMPTY_N        <= ~FIFO_EMPTY;
      ALMOST_EMPTY_N <= FIFO_COUNT > threshold_reg;
    end
  end

  always_comb begin
    status = '{
      offset_sel:       offset_sel_reg,
      swap:             swap_reg,
      endian:           endian_reg,
      width:            width_reg,
      mail_to_a_full_n: MAIL_TO_A_FULL_N,
      mail_to_b_full_n: MAIL_TO_B_FULL_N,
      almost_empty_n:   ALMOST_EMPTY_N,
      empty_n:          EMPTY_N,
      almost_full_n:    ALMOST_FULL_N,
      full_n:           FULL_N
    };
  end

  // APB slave: one wait state, then PREADY for one cycle
  assign apb_access = PSEL & PENABLE;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0;
      PSLVERR <= 1'b0;
    end else if (apb_access && !PREADY) begin
      PREADY  <= 1'b1;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0;
      if (PADDR == `DCFPC_ADDR_CTRL) begin
        PRDATA <= {29'h0, ctrl_reg};
      end else if (PADDR == `DCFPC_ADDR_STATUS) begin
        PRDATA <= {19'h0, status};
      end else if (PADDR == `DCFPC_ADDR_THRESH) begin
        PRDATA <= {25'h0, threshold_reg};
      end else begin
        PSLVERR <= 1'b1;
      end
    end else begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_reg <= `DCFPC_CTRL_RST;
    end else if (apb_access && PREADY && PWRITE
                 && PADDR == `DCFPC_ADDR_CTRL) begin
      ctrl_reg <= PWDATA[2:0];
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  property p_a_oe;
    a_wr |=> PORTA_DATA_OE_N;
  endproperty
  a_a_oe: assert property (p_a_oe)
    else $error("port A driving during write");

  property p_b_oe;
    b_wr |=> PORTB_DATA_OE_N;
  endproperty
  a_b_oe: assert property (p_b_oe)
    else $error("port B driving during write");

  property p_mail_b_fill;
    a_wr && a_s2_reg.porta_mailbox_sel && MAIL_TO_B_FULL_N
      |=> !MAIL_TO_B_FULL_N && mailbox_to_b == $past(a_s2_reg.data);
  endproperty
  a_mail_b_fill: assert property (p_mail_b_fill)
    else $error("mailbox to B not filled");

  property p_mail_b_empty;
    b_rd && b_mbox && !a_wr |=> MAIL_TO_B_FULL_N;
  endproperty
  a_mail_b_empty: assert property (p_mail_b_empty)
    else $error("mailbox to B not emptied");

  property p_mail_a_fill;
    b_wr && b_mbox && MAIL_TO_A_FULL_N |=> !MAIL_TO_A_FULL_N;
  endproperty
  a_mail_a_fill: assert property (p_mail_a_fill)
    else $error("mailbox to A not filled");

  property p_width_late;
    $changed(width_reg) |-> $past(b_edge)
      && width_reg == $past(width_pend_reg);
  endproperty
  a_width_late: assert property (p_width_late)
    else $error("bus size applied early");

  property p_a_parity;
    a_rd && a_s2_reg.porta_mailbox_sel && ctrl_reg[`DCFPC_CTRL_PGA]
      |=> (^PORTA_DATA_OUT[8:0]) == $past(ctrl_reg[`DCFPC_CTRL_ODD]);
  endproperty
  a_a_parity: assert property (p_a_parity)
    else $error("port A parity wrong");

  property p_b_parity;
    b_rd && ctrl_reg[`DCFPC_CTRL_PGB]
      |=> (^PORTB_DATA_OUT[8:0]) == $past(ctrl_reg[`DCFPC_CTRL_ODD]);
  endproperty
  a_b_parity: assert property (p_b_parity)
    else $error("port B parity wrong");

  property p_fifo_write;
    a_wr && !a_s2_reg.porta_mailbox_sel |=> FIFO_WR_REQ ##1 !FIFO_WR_REQ;
  endproperty
  a_fifo_write: assert property (p_fifo_write)
    else $error("FIFO write not one pulse");

  property p_offset_held;
    offset_taken_reg |=> $stable(threshold_reg);
  endproperty
  a_offset_held: assert property (p_offset_held)
    else $error("offset changed after reset");

endmodule : dcfpc_port_ctrl

`default_nettype wire

/* File: dcfpc_fifo_model.sv */
// Purpose: behavioural FIFO array behind the port control
// Assumes: show-ahead read data, one word moved per request
// Notes:   empty head shows the inverted last word, never a stale copy
`timescale 1ns/1ps
`default_nettype none

module dcfpc_fifo_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        rd_req,
  input  wire logic        wr_req,
  input  wire logic [35:0] wr_data,
  output var  logic [35:0] rd_data,
  output var  logic        empty,
  output var  logic        full,
  output var  logic [6:0]  count
);
  logic [35:0] mem [64];
  logic [5:0]  wp_reg;
  logic [5:0]  rp_reg;
  logic [35:0] last_reg;
  logic        wr_ok;
  logic        rd_ok;

  assign wr_ok   = wr_req && (count != 7'h40);
  assign rd_ok   = rd_req && (count != 7'h00);
  assign empty   = (count == 7'h00);
  assign full    = (count == 7'h40);
  assign rd_data = empty ? ~last_reg : mem[rp_reg];

  always_ff @(posedge clk) begin
    if (wr_ok) begin
      mem[wp_reg] <= wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_reg   <= 6'h00;
      rp_reg   <= 6'h00;
      count    <= 7'h00;
      last_reg <= 36'h000000000;
    end else begin
      wp_reg <= wp_reg + {5'h00, wr_ok};
      rp_reg <= rp_reg + {5'h00, rd_ok};
      count  <= count + {6'h00, wr_ok} - {6'h00, rd_ok};
      if (rd_ok) begin
        last_reg <= mem[rp_reg];
      end
    end
  end
endmodule : dcfpc_fifo_model
`default_nettype wire

/* File: dcfpc_port_ctrl_tb_top.sv */
// Purpose: self-checking bench of the port control
// Assumes: port pins move slowly, four CLK cycles a phase
// Notes:   APB reads and FIFO writes are checked from queues
`include "dcfpc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module dcfpc_port_ctrl_tb_top;
  import dcfpc_pkg::*;
  logic         clk;
  logic         rst;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [11:0]  paddr;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  dcfpc_porta_s pa_in;
  dcfpc_portb_s pb_in;
  logic [1:0]   fs;
  logic [35:0]  f_rd_data;
  logic         f_empty;
  logic         f_full;
  logic [6:0]   f_count;
  logic         f_rd_req;
  logic         f_wr_req;
  logic [35:0]  f_wr_data;
  logic [35:0]  a_out;
  logic         a_oe_n;
  logic [35:0]  b_out;
  logic         b_oe_n;
  logic [5:0]   flg;
  logic [32:0]  apb_q [$];
  logic [35:0]  wr_q [$];
  logic [35:0]  w [8];
  logic [35:0]  t;
  logic [31:0]  rnd = 32'h2d24;
  int           num_errors = 0;
  int           checked = 0;
  int           rd_cnt = 0;
  int           n0;

  dcfpc_port_ctrl dut (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PORTA_IN(pa_in),
    .PORTB_IN(pb_in), .FLAG_OFFSET_SEL_LO(fs[0]),
    .FLAG_OFFSET_SEL_HI(fs[1]), .FIFO_RD_DATA(f_rd_data),
    .FIFO_EMPTY(f_empty), .FIFO_FULL(f_full), .FIFO_COUNT(f_count),
    .FIFO_RD_REQ(f_rd_req), .FIFO_WR_REQ(f_wr_req),
    .FIFO_WR_DATA(f_wr_data), .PORTA_DATA_OUT(a_out),
    .PORTA_DATA_OE_N(a_oe_n), .PORTB_DATA_OUT(b_out),
    .PORTB_DATA_OE_N(b_oe_n), .FULL_N(flg[5]), .ALMOST_FULL_N(flg[4]),
    .EMPTY_N(flg[3]), .ALMOST_EMPTY_N(flg[2]),
    .MAIL_TO_B_FULL_N(flg[1]), .MAIL_TO_A_FULL_N(flg[0]));

  dcfpc_fifo_model fifo (
    .clk(clk), .rst(rst), .rd_req(f_rd_req), .wr_req(f_wr_req),
    .wr_data(f_wr_data), .rd_data(f_rd_data), .empty(f_empty),
    .full(f_full), .count(f_count));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [35:0] par(input logic [35:0] d,
                                      input logic odd);
    logic [35:0] r;
    r = d;
    for (int i = 0; i < 4; i++)
      r[9*i+8] = (^d[9*i +: 8]) ^ odd;
    return r;
  endfunction : par

  function automatic logic [35:0] swp(input logic [35:0] d,
                                      input logic [1:0] m);
    case (m)
      2'b01: return {d[26:18], d[35:27], d[8:0], d[17:9]};
      2'b10: return {d[17:0], d[35:18]};
      2'b11: return {d[8:0], d[17:9], d[26:18], d[35:27]};
      default: return d;
    endcase
  endfunction : swp

  function automatic logic [6:0] off(input int s);
    case (s)
      0: return `DCFPC_OFFSET0;
      1: return `DCFPC_OFFSET1;
      2: return `DCFPC_OFFSET2;
      default: return `DCFPC_OFFSET3;
    endcase
  endfunction : off

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] exp);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    if (!wr)
      apb_q.push_back(exp);
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Pin rise well inside the stable window of the qualifiers
  task automatic tick(input logic b);
    repeat (4) @(posedge clk);
    pb_in.portb_clock <= b;
    pa_in.porta_clock <= !b;
    repeat (4) @(posedge clk);
    pb_in.portb_clock <= 1'b0;
    pa_in.porta_clock <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : tick

  task automatic pa(input logic dir, input logic mbx, input logic [35:0] d);
    @(posedge clk);
    pa_in.porta_enable        <= 1'b1;
    pa_in.porta_direction_sel <= dir;
    pa_in.porta_mailbox_sel   <= mbx;
    pa_in.data                <= d;
    tick(1'b0);
    chk(a_oe_n, dir);
  endtask : pa

  task automatic pb(input logic en, input logic dir, input logic [1:0] ws,
                    input logic be, input logic [1:0] sw,
                    input logic [35:0] d);
    @(posedge clk);
    pb_in.portb_enable        <= en;
    pb_in.portb_direction_sel <= dir;
    {pb_in.portb_width_sel_hi, pb_in.portb_width_sel_lo} <= ws;
    pb_in.endian_sel          <= be;
    {pb_in.swap_mode_sel_hi, pb_in.swap_mode_sel_lo} <= sw;
    pb_in.data                <= d;
    tick(1'b1);
    chk(b_oe_n, dir);
  endtask : pb

  task automatic do_reset(input logic [1:0] s);
    @(posedge clk);
    rst <= 1'b1;
    fs  <= s;
    repeat (4) begin
      tick(1'b0);
      tick(1'b1);
    end
    chk(flg, 6'b010011);
    @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset

  always @(posedge clk) begin
    if (pready === 1'b1 && pwrite === 1'b0 && apb_q.size() > 0)
      chk({3'h0, pslverr, prdata}, apb_q.pop_front());
    if (f_wr_req === 1'b1 && wr_q.size() > 0)
      chk(f_wr_data, wr_q.pop_front());
    if (f_rd_req === 1'b1)
      rd_cnt++;
  end

  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    close_out();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pa_in = '0;
    pb_in = '0;
    fs    = 2'b00;
    rst   = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      do_reset(s[1:0]);
      apb(1'b0, `DCFPC_ADDR_THRESH, 32'h0, {26'h0, off(s)});
    end
    apb(1'b0, 12'h0fc, 32'h0, 33'h100000000);
    $display("test reset and offsets done");
    pa(1'b1, 1'b1, 36'h123456789);
    chk(flg[1], 1'b0);
    pa(1'b1, 1'b1, 36'hfedcba987);
    pb(1'b0, 1'b0, 2'b11, 1'b0, 2'b00, 36'h0);
    pb(1'b1, 1'b0, 2'b11, 1'b0, 2'b00, 36'h0);
    chk(b_out, 36'h123456789);
    chk(flg[1], 1'b1);
    pb(1'b1, 1'b1, 2'b11, 1'b0, 2'b00, 36'h9a5c3e1f0);
    chk(flg[0], 1'b0);
    pb(1'b1, 1'b1, 2'b11, 1'b0, 2'b00, 36'h0);
    apb(1'b1, `DCFPC_ADDR_CTRL, 32'h5, 33'h0);
    pa(1'b0, 1'b1, 36'h0);
    chk(a_out, par(36'h9a5c3e1f0, 1'b1));
    chk(flg[0], 1'b1);
    apb(1'b1, `DCFPC_ADDR_CTRL, 32'h1, 33'h0);
    pa(1'b0, 1'b1, 36'h0);
    chk(a_out, par(36'h9a5c3e1f0, 1'b0));
    $display("test mailboxes done");
    apb(1'b1, `DCFPC_ADDR_CTRL, 32'h0, 33'h0);
    n0 = rd_cnt;
    pb(1'b0, 1'b0, 2'b00, 1'b0, 2'b00, 36'h0);
    chk(rd_cnt, n0);
    for (int i = 0; i < 8; i++) begin
      rnd  = lfsr(rnd);
      w[i] = {rnd[3:0], rnd};
      wr_q.push_back(w[i]);
      pa(1'b1, 1'b0, w[i]);
      chk(flg[2], i + 1 > off(3));
    end
    for (int m = 0; m < 4; m++) begin
      pb(1'b1, 1'b0, 2'b00, 1'b0, m[1:0], 36'h0);
      chk(b_out, swp(w[m], m[1:0]));
    end
    apb(1'b1, `DCFPC_ADDR_CTRL, 32'h6, 33'h0);
    pb(1'b1, 1'b0, 2'b00, 1'b0, 2'b00, 36'h0);
    chk(b_out, par(w[4], 1'b1));
    apb(1'b1, `DCFPC_ADDR_CTRL, 32'h0, 33'h0);
    $display("test swap and parity done");
    // Width change lands one edge late, so this read is still long
    pb(1'b1, 1'b0, 2'b01, 1'b0, 2'b00, 36'h0);
    chk(b_out, w[5]);
    pb(1'b1, 1'b0, 2'b01, 1'b0, 2'b00, 36'h0);
    chk(b_out, {18'h0, w[6][17:0]});
    pb(1'b1, 1'b0, 2'b01, 1'b0, 2'b00, 36'h0);
    chk(b_out, {18'h0, w[6][35:18]});
    pb(1'b0, 1'b0, 2'b10, 1'b1, 2'b10, 36'h0);
    t = swp(w[7], 2'b10);
    for (int k = 0; k < 4; k++) begin
      pb(1'b1, 1'b0, 2'b10, 1'b1, (k == 0) ? 2'b10 : 2'b01, 36'h0);
      chk(b_out, {27'h0, t[9*(3-k) +: 9]});
    end
    chk(rd_cnt, 8);
    chk(apb_q.size() + wr_q.size(), 0);
    $display("test widths done");
    close_out();
  end
endmodule : dcfpc_port_ctrl_tb_top
`default_nettype wire
